// ===== hdl/cms_sequencer.sv
// Configuration mode sequencer: load, initialize, user mode, forced reload
`timescale 1ns/1ps
module cms_sequencer #(
    parameter int unsigned CFG_BYTES = cms_pkg::DEF_CFG_BYTES,
    parameter int unsigned TIMEOUT_CYC = cms_pkg::CFG_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Control pins
    input wire logic config_pin_n,
    input wire logic chain_enable_in_n,
    input wire logic [1:0] source_sel,
    output logic chain_enable_out_n,
    // Active serial memory
    output logic as_dclk,
    output logic as_cs_n,
    input wire logic as_data,
    // Passive serial stream
    input wire logic ps_dclk,
    input wire logic ps_data,
    // JTAG bit stream from the on-chip test port
    input wire logic jtag_bit_valid,
    input wire logic jtag_bit,
    // Configuration storage write port
    output logic cfg_wr_valid,
    output logic [7:0] cfg_wr_data,
    input wire logic cfg_wr_ready,
    // Mode report
    output cms_pkg::cms_status_t status
);
    cms_pkg::cms_state_t state_ff;
    cms_pkg::cms_src_t src_ff;
    cms_pkg::cms_status_t status_ff;
    logic [cms_pkg::NPIN-1:0] sync1_ff;
    logic [cms_pkg::NPIN-1:0] sync2_ff;
    logic ps_clk_d_ff;
    logic as_dclk_ff;
    logic as_cs_n_ff;
    logic [3:0] dcnt_ff;
    logic [7:0] shift_ff;
    logic [2:0] bit_cnt_ff;
    logic [23:0] byte_cnt_ff;
    logic [23:0] tmo_cnt_ff;
    logic [3:0] init_cnt_ff;
    logic chain_out_n_ff;
    logic loaded_ff;
    logic cfg_n_s;
    logic ce_n_s;
    logic bit_take;
    logic bit_val;
    logic push;
    logic overrun;
    logic bytes_left;
    logic load_done;
    logic timeout;
    logic buf_in_ready;

    // Every pin crosses two flops before any logic reads it
    genvar gi;
    generate
        for (gi = 0; gi < cms_pkg::NPIN; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    sync1_ff[gi] <= cms_pkg::PIN_IDLE[gi];
                    sync2_ff[gi] <= cms_pkg::PIN_IDLE[gi];
                end else begin
                    sync1_ff[gi] <= (gi == cms_pkg::PIN_CFG_N) ? config_pin_n :
                                    (gi == cms_pkg::PIN_CE_N) ? chain_enable_in_n :
                                    (gi == cms_pkg::PIN_MSEL + 1) ? source_sel[1] :
                                    (gi == cms_pkg::PIN_MSEL) ? source_sel[0] :
                                    (gi == cms_pkg::PIN_AS_D) ? as_data :
                                    (gi == cms_pkg::PIN_PS_CLK) ? ps_dclk : ps_data;
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    assign cfg_n_s = sync2_ff[cms_pkg::PIN_CFG_N];
    assign ce_n_s = sync2_ff[cms_pkg::PIN_CE_N];

    always_ff @(posedge mclk) begin
        if (!resetn)
            ps_clk_d_ff <= 1'b0;
        else
            ps_clk_d_ff <= sync2_ff[cms_pkg::PIN_PS_CLK];
    end

    assign bytes_left = (byte_cnt_ff != 24'(CFG_BYTES));
    assign load_done = !bytes_left && !cfg_wr_valid;
    assign timeout = (tmo_cnt_ff == 24'(TIMEOUT_CYC - 1));

    // Bit source follows the scheme latched at load start
    always_comb begin
        bit_take = 1'b0;
        bit_val = 1'b0;
        if (state_ff == cms_pkg::ST_LOAD && bytes_left) begin
            case (src_ff)
                cms_pkg::SRC_AS: begin
                    bit_take = as_dclk_ff && (dcnt_ff == 4'h0);
                    bit_val = sync2_ff[cms_pkg::PIN_AS_D];
                end
                cms_pkg::SRC_PS: begin
                    bit_take = sync2_ff[cms_pkg::PIN_PS_CLK] && !ps_clk_d_ff;
                    bit_val = sync2_ff[cms_pkg::PIN_PS_D];
                end
                cms_pkg::SRC_JTAG: begin
                    bit_take = jtag_bit_valid;
                    bit_val = jtag_bit;
                end
                default: begin
                    bit_take = 1'b0;
                    bit_val = 1'b0;
                end
            endcase
        end
    end

    assign push = bit_take && (bit_cnt_ff == cms_pkg::LAST_BIT);
    // Passive and JTAG sources cannot be stalled; a full buffer loses data
    assign overrun = push && !buf_in_ready;

    // Mode sequencing
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_ff <= cms_pkg::ST_POR;
        end else if (!cfg_n_s) begin
            state_ff <= cms_pkg::ST_POR;
        end else begin
            case (state_ff)
                cms_pkg::ST_POR: state_ff <= cms_pkg::ST_WAIT_CE;
                cms_pkg::ST_WAIT_CE: begin
                    if (!ce_n_s)
                        state_ff <= cms_pkg::ST_LOAD;
                end
                cms_pkg::ST_LOAD: begin
                    if (timeout || overrun)
                        state_ff <= cms_pkg::ST_ERROR;
                    else if (load_done)
                        state_ff <= cms_pkg::ST_INIT;
                end
                cms_pkg::ST_INIT: begin
                    if (init_cnt_ff == 4'h0)
                        state_ff <= cms_pkg::ST_USER;
                end
                cms_pkg::ST_USER: state_ff <= cms_pkg::ST_USER;
                cms_pkg::ST_ERROR: state_ff <= cms_pkg::ST_ERROR;
                default: state_ff <= cms_pkg::ST_POR;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn)
            src_ff <= cms_pkg::SRC_NONE;
        else if (state_ff == cms_pkg::ST_WAIT_CE)
            src_ff <= cms_cast_src(sync2_ff[cms_pkg::PIN_MSEL +: 2]);
    end

    function automatic cms_pkg::cms_src_t cms_cast_src(input logic [1:0] sel);
        cms_pkg::cms_src_t s;
        s = cms_pkg::SRC_NONE;
        case (sel)
            2'h0: s = cms_pkg::SRC_AS;
            2'h1: s = cms_pkg::SRC_PS;
            2'h2: s = cms_pkg::SRC_JTAG;
            default: s = cms_pkg::SRC_NONE;
        endcase
        return s;
    endfunction : cms_cast_src

    // Active serial clock; a new cycle starts only when the buffer has room
    always_ff @(posedge mclk) begin
        if (!resetn || state_ff != cms_pkg::ST_LOAD) begin
            as_dclk_ff <= 1'b0;
            dcnt_ff <= 4'h0;
        end else if (dcnt_ff != 4'h0) begin
            dcnt_ff <= dcnt_ff - 4'h1;
        end else if (as_dclk_ff) begin
            as_dclk_ff <= 1'b0;
            dcnt_ff <= cms_pkg::DCLK_HALF_M1;
        end else if (src_ff == cms_pkg::SRC_AS && bytes_left && buf_in_ready) begin
            as_dclk_ff <= 1'b1;
            dcnt_ff <= cms_pkg::DCLK_HALF_M1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn)
            as_cs_n_ff <= 1'b1;
        else
            as_cs_n_ff <= !(state_ff == cms_pkg::ST_LOAD && src_ff == cms_pkg::SRC_AS);
    end

    // Bit and byte assembly, first bit in the byte's top position
    always_ff @(posedge mclk) begin
        if (!resetn || state_ff != cms_pkg::ST_LOAD) begin
            shift_ff <= 8'h00;
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 24'h000000;
        end else if (bit_take) begin
            shift_ff <= {shift_ff[6:0], bit_val};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (push)
                byte_cnt_ff <= byte_cnt_ff + 24'h000001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn || state_ff != cms_pkg::ST_LOAD)
            tmo_cnt_ff <= 24'h000000;
        else
            tmo_cnt_ff <= tmo_cnt_ff + 24'h000001;
    end

    always_ff @(posedge mclk) begin
        if (!resetn || state_ff != cms_pkg::ST_INIT)
            init_cnt_ff <= cms_pkg::INIT_CYC;
        else if (init_cnt_ff != 4'h0)
            init_cnt_ff <= init_cnt_ff - 4'h1;
    end

    always_ff @(posedge mclk) begin
        if (!resetn || state_ff == cms_pkg::ST_POR)
            loaded_ff <= 1'b0;
        else if (state_ff == cms_pkg::ST_LOAD && load_done)
            loaded_ff <= 1'b1;
    end

    // Mode report and chain hand-off
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status_ff <= '0;
            chain_out_n_ff <= 1'b1;
        end else begin
            status_ff.user_mode <= (state_ff == cms_pkg::ST_USER);
            status_ff.io_enable <= (state_ff == cms_pkg::ST_USER);
            status_ff.init_reset <= (state_ff == cms_pkg::ST_INIT);
            status_ff.error <= (state_ff == cms_pkg::ST_ERROR);
            chain_out_n_ff <= !(state_ff == cms_pkg::ST_INIT ||
                                state_ff == cms_pkg::ST_USER);
        end
    end

    cms_buf u_buf (
        .mclk(mclk),
        .resetn(resetn),
        .flush(state_ff == cms_pkg::ST_POR),
        .in_valid(push),
        .in_data({shift_ff[6:0], bit_val}),
        .in_ready(buf_in_ready),
        .out_valid(cfg_wr_valid),
        .out_data(cfg_wr_data),
        .out_ready(cfg_wr_ready)
    );

    assign as_dclk = as_dclk_ff;
    assign as_cs_n = as_cs_n_ff;
    assign chain_enable_out_n = chain_out_n_ff;
    assign status = status_ff;

    a_user_needs_load: assert property (@(posedge mclk) disable iff (!resetn)
        (state_ff == cms_pkg::ST_USER) |-> loaded_ff)
        else $error("user state reached without a completed load");
    a_init_then_user: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(status_ff.user_mode) |-> $past(status_ff.init_reset, 1))
        else $error("user mode entered without initialization");
    a_mode_report: assert property (@(posedge mclk) disable iff (!resetn)
        (state_ff == cms_pkg::ST_USER) |=> status_ff.user_mode)
        else $error("user state not reported");
    a_pin_forces_cmd: assert property (@(posedge mclk) disable iff (!resetn)
        !cfg_n_s |=> (state_ff == cms_pkg::ST_POR) ##1 !status_ff.user_mode)
        else $error("reconfiguration pin did not force command state");
    a_io_off_cmd: assert property (@(posedge mclk) disable iff (!resetn)
        (state_ff != cms_pkg::ST_USER) |=> !status_ff.io_enable)
        else $error("I/O enabled outside user state");
    a_as_controller: assert property (@(posedge mclk) disable iff (!resetn)
        as_dclk_ff |-> (!as_cs_n_ff && src_ff == cms_pkg::SRC_AS))
        else $error("serial clock driven without memory select");
    a_dclk_high_time: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(as_dclk_ff) |-> (as_dclk_ff || as_cs_n_ff)[*4] ##1 !as_dclk_ff)
        else $error("serial clock high time wrong");
    a_load_needs_ce: assert property (@(posedge mclk) disable iff (!resetn)
        (state_ff == cms_pkg::ST_WAIT_CE && ce_n_s) |=> (state_ff != cms_pkg::ST_LOAD))
        else $error("load started without chain enable");
    a_chain_out: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(chain_out_n_ff) |-> $past(loaded_ff, 1))
        else $error("chain enable output asserted before load done");
endmodule : cms_sequencer

// ===== hdl/cms_pkg.sv
// Constants, states and carriers of the configuration mode sequencer
// Function
// - Configuration storage is empty after every power-up and must be loaded again.
// - After loading, reset internal registers, enable I/O, then act as configured logic.
// - Loading plus initialization is command state; normal operation is user state; report it.
// - A dedicated pin forces command state; the device reloads, reinitializes, returns to user.
// - User I/O pins are not driven before or during configuration; only weak pull-ups.
// - Three data sources: active serial memory, passive serial stream, and JTAG port.
// - In active serial the device is controller and clocks the memory read itself.
// - Serial data clock runs at 20 MHz (the code runs it at 125 MHz / 8, 15.625 MHz); full configuration completes within 120 ms.
// - Devices chain: each enable output drives the next device's enable input.
package cms_pkg;
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned DCLK_HZ = 20_000_000;
    // Least period rounds up, so the clock never runs above its limit
    localparam int unsigned DCLK_CYC = (CLK_HZ + DCLK_HZ - 1) / DCLK_HZ;
    localparam int unsigned DCLK_HALF = (DCLK_CYC + 1) / 2;
    localparam logic [3:0] DCLK_HALF_M1 = 4'(DCLK_HALF - 1);
    localparam int unsigned CFG_TIME_MS = 120;
    localparam int unsigned CFG_TIMEOUT_CYC = CFG_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned DEF_CFG_BYTES = 65536;
    localparam logic [3:0] INIT_CYC = 4'h8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Pin order in the synchroniser vector and its idle level
    localparam int unsigned NPIN = 7;
    localparam logic [6:0] PIN_IDLE = 7'h60;
    localparam int unsigned PIN_CFG_N = 6;
    localparam int unsigned PIN_CE_N = 5;
    localparam int unsigned PIN_MSEL = 3;
    localparam int unsigned PIN_AS_D = 2;
    localparam int unsigned PIN_PS_CLK = 1;
    localparam int unsigned PIN_PS_D = 0;

    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_WAIT_CE = 3'b001,
        ST_LOAD = 3'b010,
        ST_INIT = 3'b011,
        ST_USER = 3'b100,
        ST_ERROR = 3'b101
    } cms_state_t;

    typedef enum logic [1:0] {
        SRC_AS = 2'b00,
        SRC_PS = 2'b01,
        SRC_JTAG = 2'b10,
        SRC_NONE = 2'b11
    } cms_src_t;

    typedef struct packed {
        logic user_mode;
        logic io_enable;
        logic init_reset;
        logic error;
    } cms_status_t;
endpackage : cms_pkg

// ===== hdl/cms_buf.sv
// Two-entry configuration byte buffer with registered outputs
`timescale 1ns/1ps
module cms_buf (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);
    logic v0_ff;
    logic v1_ff;
    logic [7:0] d0_ff;
    logic [7:0] d1_ff;
    logic push;
    logic pop;

    assign in_ready = ~v1_ff;
    assign out_valid = v0_ff;
    assign out_data = d0_ff;
    assign push = in_valid & ~v1_ff;
    assign pop = v0_ff & out_ready;

    always_ff @(posedge mclk) begin
        if (!resetn || flush) begin
            v0_ff <= 1'b0;
            v1_ff <= 1'b0;
            d0_ff <= 8'h00;
            d1_ff <= 8'h00;
        end else if (pop) begin
            if (v1_ff) begin
                d0_ff <= d1_ff;
                v1_ff <= 1'b0;
            end else if (push) begin
                d0_ff <= in_data;
            end else begin
                v0_ff <= 1'b0;
            end
        end else if (push) begin
            if (v0_ff) begin
                d1_ff <= in_data;
                v1_ff <= 1'b1;
            end else begin
                d0_ff <= in_data;
                v0_ff <= 1'b1;
            end
        end
    end
endmodule : cms_buf

// ===== testbench/cms_mem_model.sv
// Serial configuration memory model driven by the active serial clock
`timescale 1ns/1ps
module cms_mem_model (
    // Serial port
    input wire logic as_dclk,
    input wire logic as_cs_n,
    output logic as_data
);
    int unsigned bit_idx = 0;
    logic [7:0] cur;
    initial as_data = 1'b1;
    task automatic put_bit;
        cur = 8'hC3 + 8'h35 * 8'(bit_idx >> 3);
        as_data = cur[~3'(bit_idx)];
    endtask : put_bit
    // Every select restarts at byte zero, MSB first
    always @(negedge as_cs_n) begin
        bit_idx = 0;
        put_bit();
    end
    // Next bit only when the sequencer clocks it out
    always @(negedge as_dclk) begin
        if (!as_cs_n) begin
            bit_idx = bit_idx + 1;
            put_bit();
        end
    end
    // Deselected line has no pull: show the inverse, not the last bit
    always @(posedge as_cs_n) as_data = ~as_data;
endmodule : cms_mem_model

// ===== testbench/cms_sequencer_tb.sv
// Self-checking bench for the configuration mode sequencer
`timescale 1ns/1ps
module cms_sequencer_tb;
    localparam int unsigned NBYTES = 4;
    localparam int unsigned TMO = 2000;
    logic mclk, resetn, config_pin_n, chain_enable_in_n, chain_enable_out_n;
    logic [1:0] source_sel;
    logic as_dclk, as_cs_n, as_data, ps_dclk, ps_data, jtag_bit_valid, jtag_bit;
    logic cfg_wr_valid, cfg_wr_ready;
    logic [7:0] cfg_wr_data;
    cms_pkg::cms_status_t status;
    int err_total = 0;
    int num_checks = 0;

    cms_sequencer #(.CFG_BYTES(NBYTES), .TIMEOUT_CYC(TMO)) u_dut (
        .mclk(mclk), .resetn(resetn), .config_pin_n(config_pin_n),
        .chain_enable_in_n(chain_enable_in_n), .source_sel(source_sel),
        .chain_enable_out_n(chain_enable_out_n), .as_dclk(as_dclk), .as_cs_n(as_cs_n),
        .as_data(as_data), .ps_dclk(ps_dclk), .ps_data(ps_data),
        .jtag_bit_valid(jtag_bit_valid), .jtag_bit(jtag_bit), .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_data(cfg_wr_data), .cfg_wr_ready(cfg_wr_ready), .status(status)
    );
    cms_mem_model u_mem (.as_dclk(as_dclk), .as_cs_n(as_cs_n), .as_data(as_data));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    function automatic logic [7:0] exp_byte(input int i);
        return 8'hC3 + 8'h35 * 8'(i);
    endfunction : exp_byte

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    // Storage side; a long stall fills the buffer and must lose nothing
    task automatic drain(input int stall);
        int cnt;
        for (int i = 0; i < NBYTES; i++) begin
            cnt = 0;
            while (cfg_wr_valid !== 1'b1 && cnt < 3000) begin
                cfg_wr_ready = 1'b0;
                @(negedge mclk);
                cnt++;
            end
            if (stall > 0) begin
                cfg_wr_ready = 1'b0;
                repeat (stall) @(negedge mclk);
            end
            check(cfg_wr_valid, 1'b1, "byte valid");
            check(cfg_wr_data, exp_byte(i), "byte data");
            // Ready stays up across back-to-back bytes only when stall is zero
            cfg_wr_ready = 1'b1;
            @(negedge mclk);
        end
        cfg_wr_ready = 1'b0;
    endtask : drain

    // Initialization then user mode, pins released only at the end
    task automatic finish_check;
        int cnt;
        cnt = 0;
        while (status.init_reset !== 1'b1 && cnt < 30) begin
            @(negedge mclk);
            cnt++;
        end
        cnt = 0;
        while (status.init_reset === 1'b1 && cnt < 40) begin
            check(status.io_enable, 1'b0, "io during init");
            check(chain_enable_out_n, 1'b0, "chain out in init");
            @(negedge mclk);
            cnt++;
        end
        // State holds one more cycle while the counter reads zero
        check(8'(cnt), 8'(cms_pkg::INIT_CYC) + 8'h01, "init length");
        repeat (3) @(negedge mclk);
        check(status.user_mode, 1'b1, "user mode");
        check(status.io_enable, 1'b1, "io in user");
        check(status.error, 1'b0, "no error");
    endtask : finish_check

    // Pin-forced return to command state, then a new source
    task automatic reload(input logic [1:0] src);
        config_pin_n = 1'b0;
        repeat (6) @(negedge mclk);
        check(status.user_mode, 1'b0, "command state");
        check(status.io_enable, 1'b0, "io released");
        check(chain_enable_out_n, 1'b1, "chain out off");
        source_sel = src;
        config_pin_n = 1'b1;
    endtask : reload

    task automatic send(input logic jtag);
        logic [7:0] v;
        // Pin sync and chain enable need four cycles before bits count
        repeat (6) @(negedge mclk);
        for (int i = 0; i < NBYTES; i++) begin
            v = exp_byte(i);
            for (int b = 7; b >= 0; b--) begin
                if (jtag) begin
                    jtag_bit = v[b];
                    jtag_bit_valid = 1'b1;
                    @(negedge mclk);
                    jtag_bit_valid = 1'b0;
                    jtag_bit = ~jtag_bit;
                    repeat (3) @(negedge mclk);
                end else begin
                    ps_data = v[b];
                    repeat (4) @(negedge mclk);
                    ps_dclk = 1'b1;
                    repeat (4) @(negedge mclk);
                    ps_dclk = 1'b0;
                end
            end
        end
        // Stream released: line no longer holds its last bit
        ps_data = ~ps_data;
    endtask : send

    task automatic t_stream(input logic jtag);
        reload(jtag ? 2'h2 : 2'h1);
        fork
            send(jtag);
            drain(0);
        join
        finish_check();
    endtask : t_stream

    // Unstallable stream into a stalled store must end in error
    task automatic t_overrun;
        reload(2'h2);
        send(1'b1);
        check(status.error, 1'b1, "overrun error");
        check(status.user_mode, 1'b0, "no user on overrun");
    endtask : t_overrun

    // Passive with no stream, or no source at all
    task automatic t_timeout(input logic [1:0] src);
        int cnt;
        reload(src);
        cnt = 0;
        while (status.error !== 1'b1 && cnt < TMO + 200) begin
            @(negedge mclk);
            cnt++;
        end
        check(status.error, 1'b1, "timeout error");
        check(status.user_mode, 1'b0, "no user on error");
        check(chain_enable_out_n, 1'b1, "no chain on error");
        check(as_cs_n, 1'b1, "no select on error");
    endtask : t_timeout

    task automatic t_chain_hold;
        chain_enable_in_n = 1'b1;
        reload(2'h0);
        repeat (100) @(negedge mclk);
        check(as_cs_n, 1'b1, "no select while held");
        check(as_dclk, 1'b0, "no clock while held");
        check(cfg_wr_valid, 1'b0, "no data while held");
        check(status.error, 1'b0, "error cleared");
        chain_enable_in_n = 1'b0;
        drain(3);
        finish_check();
    endtask : t_chain_hold

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        resetn = 1'b0;
        config_pin_n = 1'b1;
        chain_enable_in_n = 1'b0;
        source_sel = 2'h0;
        ps_dclk = 1'b0;
        ps_data = 1'b0;
        jtag_bit_valid = 1'b0;
        jtag_bit = 1'b0;
        cfg_wr_ready = 1'b0;
        repeat (10) @(negedge mclk);
        check(8'(status), 8'h00, "status in reset");
        check(chain_enable_out_n, 1'b1, "chain out in reset");
        check(as_cs_n, 1'b1, "select in reset");
        repeat (6) @(negedge mclk);
        resetn = 1'b1;
        // Active serial right after power-up, with a stalling receiver
        drain(150);
        finish_check();
        t_stream(1'b0);
        t_stream(1'b1);
        t_overrun();
        t_timeout(2'h1);
        t_timeout(2'h3);
        t_chain_hold();
        end_of_test();
    end
endmodule : cms_sequencer_tb
